/* File: bench/fspc_flash_model.sv */
`timescale 1ns/1ps
module fspc_flash_model
   import fspc_pkg::*;
(
   // Clock and request
   input  wire logic              ref_clk,
   input  wire logic              flashValid,
   input  wire fspc_freq_t        flashReq,
   input  wire logic              failNext,
   // Answer
   output logic                   flashAck,
   output logic                   flashFail,
   output logic      [WORD_W-1:0] flashRdData,
   output logic      [WORD_W-1:0] lastAddr
);
   logic [23:0] mem [int];
   logic [23:0] dflt = 24'h0;
   int          dly  = 0;

   initial {flashAck, flashFail, flashRdData, lastAddr} = '0;

   // Random wait; idle outputs toggle
   always @(posedge ref_clk) begin
      flashRdData <= ~flashRdData;
      flashFail <= ~flashFail;
      flashAck <= 1'b0;
      if (flashValid && !flashAck) begin
         if (dly > 0)
            dly <= dly - 1;
         else begin
            dly <= $urandom_range(0, 3);
            flashAck <= 1'b1;
            flashFail <= failNext;
            lastAddr <= flashReq.addr;
            case (flashReq.cmd)
               FCMD_READ: flashRdData <= mem.exists(flashReq.addr) ? mem[flashReq.addr] : dflt;
               FCMD_BULK_ERASE: begin
                  mem.delete();
                  dflt = 24'hFFFFFF;
               end
               // No alignment here, so a bad base shows
               FCMD_PAGE_ERASE: for (int i = 0; i < 1024; i += 2) mem[flashReq.addr + i] = 24'hFFFFFF;
               default: if (!failNext) mem[flashReq.addr] = flashReq.data;
            endcase
         end
      end
   end
endmodule : fspc_flash_model

/* File: bench/fspc_properties.sv */
`timescale 1ns/1ps
module fspc_properties
   import fspc_pkg::*;
(
   // Clock and reset
   input wire logic              ref_clk,
   input wire logic              rst,
   // Register bus
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   // Stall and flash port
   input wire logic              cpuStall,
   input wire logic              flashValid,
   input wire fspc_freq_t        flashReq,
   input wire logic              flashAck
);
   // ------------------------------------------------------------
   // Row word counter
   // ------------------------------------------------------------
   logic [6:0] rowCnt_ff;

   always_ff @(posedge ref_clk) begin
      if (rst || !cpuStall)
         rowCnt_ff <= 7'h00;
      else if (flashValid && flashAck && flashReq.cmd == FCMD_ROW_PROG)
         rowCnt_ff <= rowCnt_ff + 7'h01;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_twrite_ack: assert property (avs_write && avs_waitrequest && !cpuStall && !flashValid &&
      (avs_address == REG_TLOW || avs_address == REG_THIGH) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("table write ack late");
   a_stall_bus: assert property (cpuStall |-> avs_waitrequest)
      else $error("ack while stalled");
   a_prog_stall: assert property (flashValid && flashReq.cmd != FCMD_READ |-> cpuStall)
      else $error("array op unstalled");
   a_req_hold: assert property (flashValid && !flashAck |=> flashValid && $stable(flashReq))
      else $error("request unstable");
   a_req_drop: assert property (flashValid && flashAck |=> !flashValid)
      else $error("request not dropped");
   a_row_index: assert property (flashValid && flashReq.cmd == FCMD_ROW_PROG |->
      flashReq.addr[6:1] == rowCnt_ff[5:0])
      else $error("row order");
   a_row_count: assert property ($fell(cpuStall) && rowCnt_ff != 7'h00 |-> rowCnt_ff == 7'h40)
      else $error("row length wrong");
   a_op_finish: assert property (flashValid && flashAck && flashReq.cmd != FCMD_READ &&
      (flashReq.cmd != FCMD_ROW_PROG || flashReq.addr[6:1] == ROW_LAST) |-> ##2 !cpuStall && !avs_waitrequest)
      else $error("op end late");
   a_rsvd_zero: assert property (avs_read && !avs_waitrequest && avs_address == REG_CTRL |->
      avs_readdata[12:7] == 6'h00 && avs_readdata[5:4] == 2'h0 && !avs_readdata[15])
      else $error("reserved bits set");
   a_unmapped: assert property (avs_read && !avs_waitrequest && avs_address[3] |-> avs_readdata == 32'h0)
      else $error("unmapped not zero");
endmodule : fspc_properties

bind fspc_top fspc_properties u_fspc_properties (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .cpuStall(cpuStall), .flashValid(flashValid), .flashReq(flashReq), .flashAck(flashAck));

/* File: bench/fspc_top_tb.sv */
`timescale 1ns/1ps
module fspc_top_tb
   import fspc_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        cpuStall;
   logic        flashValid;
   logic        flashAck;
   logic        flashFail;
   logic        failNext = 1'b0;
   fspc_freq_t  flashReq;
   logic [23:0] flashRdData;
   logic [23:0] lastAddr;
   logic [31:0] q;
   logic [23:0] img [64];
   logic [23:0] base;
   logic [23:0] row;
   int          j;
   int          n_mismatch = 0;
   int          checks_done = 0;

   always #10 ref_clk = ~ref_clk;

   fspc_top u_fspc_top (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpuStall(cpuStall),
      .flashValid(flashValid), .flashReq(flashReq), .flashAck(flashAck), .flashFail(flashFail),
      .flashRdData(flashRdData));
   fspc_flash_model u_fspc_flash_model (.ref_clk(ref_clk), .flashValid(flashValid), .flashReq(flashReq),
      .failNext(failNext), .flashAck(flashAck), .flashFail(flashFail), .flashRdData(flashRdData),
      .lastAddr(lastAddr));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   task automatic cmp(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   function automatic logic [31:0] ctrlExp(input logic [15:0] c, input logic bad);
      return {16'h0000, (c & 16'h604F) | (bad ? 16'h2000 : 16'h0000)};
   endfunction : ctrlExp

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      for (n = 0; n < 5000 && avs_waitrequest !== 1'b0; n++)
         @(negedge ref_clk);
      if (n == 5000) begin
         n_mismatch++;
         results();
      end
      q = avs_readdata;
      @(posedge ref_clk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp(q, e);
   endtask : rd

   task automatic key;
      wr(REG_KEY, 32'h55);
      wr(REG_KEY, 32'hAA);
   endtask : key

   task automatic setAddr(input logic [23:0] a);
      wr(REG_PAGE, {24'h0, a[23:16]});
      wr(REG_EA, {16'h0, a[15:0]});
   endtask : setAddr

   task automatic rdw(input logic [23:0] a, input logic [23:0] e);
      logic [15:0] w;
      setAddr(a);
      bus(1'b0, REG_TLOW, 32'h0);
      w = q[15:0];
      bus(1'b0, REG_THIGH, 32'h0);
      cmp({8'h0, q[7:0], w}, {8'h0, e});
   endtask : rdw

   task automatic ltw(input logic [23:0] a, input logic [23:0] d);
      setAddr(a);
      wr(REG_TLOW, {16'h0, d[15:0]});
      wr(REG_THIGH, {24'h0, d[23:16]});
   endtask : ltw

   task automatic run(input logic [15:0] c, input logic bad);
      wr(REG_CTRL, {16'h0, c & 16'h5FFF});
      key();
      wr(REG_CTRL, {16'h0, c});
      rd(REG_CTRL, ctrlExp(c, bad));
   endtask : run

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hDF4BCE31));
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(REG_CTRL, 32'h0);
      rd(4'hB, 32'h0);
      wr(REG_CTRL, 32'h7FFF);
      rd(REG_CTRL, ctrlExp(16'h7FFF, 1'b0));
      wr(REG_CTRL, 32'h4001);
      wr(REG_CTRL, 32'hC001);
      rd(REG_CTRL, ctrlExp(16'h4001, 1'b1));
      wr(REG_CTRL, 32'h4001);
      key();
      wr(REG_PAGE, 32'h0);
      wr(REG_CTRL, 32'hC001);
      rd(REG_CTRL, ctrlExp(16'h4001, 1'b1));
      run(16'h8001, 1'b1);
      run(16'hC041, 1'b0);
      run(16'hC045, 1'b1);
      // Erase from an unaligned address
      base = 24'($urandom) & 24'h7FF800;
      row = base + 24'(128 * $urandom_range(0, 5));
      setAddr(base | 24'($urandom_range(0, 1023)));
      run(16'hC042, 1'b0);
      rdw(base, 24'hFFFFFF);
      rdw(base + 24'h3FE, 24'hFFFFFF);
      rdw(base + 24'h400, 24'h0);
      cmp({8'h0, lastAddr}, {8'h0, base + 24'h400});
      // Out-of-order latch loads, one rewrite
      ltw(row + 24'hA, 24'h123456);
      for (int i = 0; i < 64; i++) begin
         j = (i * 37) % 64;
         img[j] = 24'($urandom);
         ltw(row + 24'(2 * j), img[j]);
      end
      rdw(row, 24'hFFFFFF);
      run(16'hC001, 1'b0);
      for (int i = 0; i < 64; i++)
         rdw(row + 24'(2 * i), img[i]);
      wr(REG_TMODE, 32'h1);
      setAddr(row + 24'h1);
      rd(REG_TLOW, {24'h0, img[0][15:8]});
      rd(REG_THIGH, 32'h0);
      setAddr(row);
      rd(REG_TLOW, {24'h0, img[0][7:0]});
      rd(REG_THIGH, {24'h0, img[0][23:16]});
      wr(REG_TMODE, 32'h0);
      // Word program: failed, then clean
      img[1] = 24'($urandom);
      ltw(base + 24'h300, img[1]);
      failNext <= 1'b1;
      run(16'hC003, 1'b1);
      failNext <= 1'b0;
      rdw(base + 24'h300, 24'hFFFFFF);
      run(16'hC003, 1'b0);
      rdw(base + 24'h300, img[1]);
      run(16'hC04F, 1'b0);
      rdw(row, 24'hFFFFFF);
      results();
   end
endmodule : fspc_top_tb

/* File: hw/fspc_pkg.sv */
package fspc_pkg;

   // ------------------------------------------------------------
   // Register map (word index on the bus)
   // ------------------------------------------------------------
   localparam int         ADDR_W     = 4;
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_KEY    = 4'h1;
   localparam logic [3:0] REG_PAGE   = 4'h2;
   localparam logic [3:0] REG_EA     = 4'h3;
   localparam logic [3:0] REG_TLOW   = 4'h4;
   localparam logic [3:0] REG_THIGH  = 4'h5;
   localparam logic [3:0] REG_TMODE  = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam logic [15:0] CTRL_RESET   = 16'h0000;
   localparam logic [15:0] CTRL_WR_MASK = 16'h604F;
   localparam int          CTRL_START   = 15;
   localparam logic [3:0]  OP_BULK_ERASE = 4'hF;
   localparam logic [3:0]  OP_WORD_PROG  = 4'h3;
   localparam logic [3:0]  OP_PAGE_ERASE = 4'h2;
   localparam logic [3:0]  OP_ROW_PROG   = 4'h1;

   // ------------------------------------------------------------
   // Unlock key, modes, status
   // ------------------------------------------------------------
   localparam logic [7:0]  KEY_FIRST   = 8'h55;
   localparam logic [7:0]  KEY_SECOND  = 8'hAA;
   localparam int          TMODE_BYTE  = 0;
   localparam int          STAT_BUSY   = 0;
   localparam int          STAT_ARMED  = 1;
   localparam logic [7:0]  PAGE_RESET  = 8'h00;
   localparam logic [15:0] EA_RESET    = 16'h0000;

   // ------------------------------------------------------------
   // Program space geometry
   // ------------------------------------------------------------
   localparam int         WORD_W     = 24;
   localparam int         ROW_WORDS  = 64;
   localparam int         ROW_IDX_W  = 6;
   localparam int         ROW_LSB    = 1;
   localparam int         ROW_MSB    = 6;
   localparam int         ROW_BASE   = 7;
   localparam int         BLOCK_BASE = 10;
   localparam int         PAGE_CFG   = 7;
   localparam logic [5:0] ROW_LAST   = 6'h3F;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FCMD_READ        = 3'h0,
      FCMD_WORD_PROG   = 3'h1,
      FCMD_ROW_PROG    = 3'h2,
      FCMD_PAGE_ERASE  = 3'h3,
      FCMD_BULK_ERASE  = 3'h4
   } fspc_fcmd_t;

   typedef struct packed {
      logic       start;
      logic       enable;
      logic       err;
      logic [5:0] rsvdHi;
      logic       erase;
      logic [1:0] rsvdLo;
      logic [3:0] op;
   } fspc_ctrl_t;

   typedef struct packed {
      fspc_fcmd_t  cmd;
      logic [23:0] addr;
      logic [23:0] data;
   } fspc_freq_t;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_ACK      = 3'h1,
      ST_RD_WAIT  = 3'h2,
      ST_OP_ISSUE = 3'h3,
      ST_OP_WAIT  = 3'h4,
      ST_OP_END   = 3'h5
   } fspc_state_t;

endpackage : fspc_pkg

/* File: hw/fspc_row_latch.sv */
`timescale 1ns/1ps
module fspc_row_latch
   import fspc_pkg::*;
(
   // Clock
   input  wire logic                 ref_clk,
   // Write port
   input  wire logic                 program_erase_enable,
   input  wire logic [ROW_IDX_W-1:0] wrIdx,
   input  wire logic [2:0]           wrLanes,
   input  wire logic [WORD_W-1:0]    wrData,
   // Read port
   input  wire logic [ROW_IDX_W-1:0] rdIdx,
   output logic      [WORD_W-1:0]    rdData
);

   // Not reset: power up unknown
   logic [WORD_W-1:0] latchMem [ROW_WORDS];

   always_ff @(posedge ref_clk) begin
      for (int g = 0; g < 3; g++) begin
         if (program_erase_enable && wrLanes[g]) begin
            latchMem[wrIdx][g*8 +: 8] <= wrData[g*8 +: 8];
         end
      end
   end

   assign rdData = latchMem[rdIdx];

endmodule : fspc_row_latch

/* File: hw/fspc_top.sv */
// How it works
// - Address is page field over 16-bit effective address.
// - Low table access reaches bits 15..0, word or byte.
// - High table access reaches bits 23..16, word or byte.
// - Rows of 64 words; row or single-word program.
// - Page erase clears eight rows, 512 words.
// - Row and erase blocks aligned; low bits ignored.
// - Table writes fill latches outside config space (page bit 7); array changes only on an operation.
// - Any number of latch writes; 64 fill a row.
// - Latch writes in any order; later writes replace.
// - A table write is a two-cycle latch write.
// - Start needs keys 55h then AAh just before.
// - Processor stalls until erase or program ends.
// - Start bit launches and self-clears at the end.
// - Start only set by software; control resets to zero.
// - Error flag set by hardware, software read/writable.
// - Unused control bits read zero, ignore writes.
// - Enable bit low blocks every start.
// - Error flag set on bad sequence or failure, cleared on clean end.
// - Erase select: one erases, zero programs.
// - Codes: F bulk erase, 3 word, 2 page erase, 1 row.
`timescale 1ns/1ps
module fspc_top
   import fspc_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   // Processor stall
   output logic                   cpuStall,
   // Flash array port
   output logic                   flashValid,
   output fspc_freq_t             flashReq,
   input  wire logic              flashAck,
   input  wire logic              flashFail,
   input  wire logic [WORD_W-1:0] flashRdData
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   fspc_state_t          state_ff;
   fspc_state_t          nxt_state;
   fspc_ctrl_t           ctrl_ff;
   logic [7:0]           page_ff;
   logic [15:0]          ea_ff;
   logic                 byteMode_ff;
   logic [ROW_IDX_W-1:0] idx_ff;
   logic                 opFail_ff;
   logic                 rdHigh_ff;
   logic [31:0]          rdData_ff;
   logic                 waitReq_ff;
   logic                 stall_ff;
   logic                 fValid_ff;
   fspc_freq_t           fReq_ff;
   logic                 armed;

   assign avs_readdata    = rdData_ff;
   assign avs_waitrequest = waitReq_ff;
   assign cpuStall        = stall_ff;
   assign flashValid      = fValid_ff;
   assign flashReq        = fReq_ff;

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   logic        take;
   logic        wrTake;
   logic        rdTake;
   logic [23:0] tblAddr;
   logic        cfgSpace;
   logic        tblRd;
   logic        tblWr;

   assign take     = (state_ff == ST_IDLE) && (avs_read || avs_write);
   assign wrTake   = take && avs_write;
   assign rdTake   = take && !avs_write;
   assign tblAddr  = {page_ff, ea_ff};
   assign cfgSpace = page_ff[PAGE_CFG];
   assign tblRd    = rdTake && (avs_address == REG_TLOW || avs_address == REG_THIGH);
   assign tblWr    = wrTake && (avs_address == REG_TLOW || avs_address == REG_THIGH);

   // ------------------------------------------------------------
   // Control write and start decision
   // ------------------------------------------------------------
   logic [15:0] laneMask;
   logic [15:0] ctrlMerged;
   fspc_ctrl_t  ctrlNew;
   logic        ctrlWr;
   logic        startReq;
   logic        opKnown;
   logic        opMatch;
   logic        launch;
   logic        badSeq;

   assign laneMask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & CTRL_WR_MASK;
   assign ctrlMerged = (ctrl_ff & ~laneMask) | (avs_writedata[15:0] & laneMask);
   assign ctrlNew    = ctrlMerged;
   assign ctrlWr     = wrTake && (avs_address == REG_CTRL);
   assign startReq   = ctrlWr && avs_byteenable[1] && avs_writedata[CTRL_START];

   always_comb begin
      opKnown = 1'b1;
      opMatch = 1'b0;
      case (ctrlNew.op)
         OP_BULK_ERASE: opMatch = ctrlNew.erase;
         OP_PAGE_ERASE: opMatch = ctrlNew.erase;
         OP_WORD_PROG:  opMatch = !ctrlNew.erase;
         OP_ROW_PROG:   opMatch = !ctrlNew.erase;
         default:       opKnown = 1'b0;
      endcase
   end

   assign launch = startReq && ctrlNew.enable && armed && opMatch;
   assign badSeq = startReq && (!ctrlNew.enable || !armed || !opKnown);

   // ------------------------------------------------------------
   // Unlock key tracker
   // ------------------------------------------------------------
   fspc_unlock_key u_key (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .keyWr    (wrTake && (avs_address == REG_KEY)),
      .keyByte  (avs_writedata[7:0]),
      .otherWr  (wrTake && (avs_address != REG_KEY)),
      .armed_ff (armed)
   );

   // ------------------------------------------------------------
   // Holding latches
   // ------------------------------------------------------------
   logic [2:0]           latchLanes;
   logic [WORD_W-1:0]    latchWrData;
   logic [WORD_W-1:0]    latchRdData;
   logic [ROW_IDX_W-1:0] latchRdIdx;
   logic                 rowOp;

   always_comb begin
      latchLanes  = 3'h0;
      latchWrData = 24'h000000;
      if (avs_address == REG_TLOW) begin
         if (!byteMode_ff) begin
            latchLanes  = 3'h3;
            latchWrData = {8'h00, avs_writedata[15:0]};
         end else if (ea_ff[0]) begin
            latchLanes  = 3'h2;
            latchWrData = {8'h00, avs_writedata[7:0], 8'h00};
         end else begin
            latchLanes  = 3'h1;
            latchWrData = {16'h0000, avs_writedata[7:0]};
         end
      end else if (!byteMode_ff || !ea_ff[0]) begin
         latchLanes  = 3'h4;
         latchWrData = {avs_writedata[7:0], 16'h0000};
      end
   end

   assign rowOp      = (ctrl_ff.op == OP_ROW_PROG);
   assign latchRdIdx = rowOp ? idx_ff : tblAddr[ROW_MSB:ROW_LSB];

   fspc_row_latch u_latch (
      .ref_clk (ref_clk),
      .program_erase_enable    (tblWr && !cfgSpace),
      .wrIdx   (tblAddr[ROW_MSB:ROW_LSB]),
      .wrLanes (latchLanes),
      .wrData  (latchWrData),
      .rdIdx   (latchRdIdx),
      .rdData  (latchRdData)
   );

   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------
   logic opDone;

   assign opDone = (state_ff == ST_OP_WAIT) && flashAck && !(rowOp && idx_ff != ROW_LAST);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (launch) begin
               nxt_state = ST_OP_ISSUE;
            end else if (tblRd) begin
               nxt_state = ST_RD_WAIT;
            end else if (take) begin
               nxt_state = ST_ACK;
            end
         end
         ST_ACK:      nxt_state = ST_IDLE;
         ST_RD_WAIT:  nxt_state = flashAck ? ST_ACK : ST_RD_WAIT;
         ST_OP_ISSUE: nxt_state = ST_OP_WAIT;
         ST_OP_WAIT: begin
            if (opDone) begin
               nxt_state = ST_OP_END;
            end else if (flashAck) begin
               nxt_state = ST_OP_ISSUE;
            end
         end
         ST_OP_END:   nxt_state = ST_ACK;
         default:     nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_ff   <= ST_IDLE;
         waitReq_ff <= 1'b1;
         stall_ff   <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         waitReq_ff <= (nxt_state != ST_ACK);
         stall_ff   <= (nxt_state == ST_OP_ISSUE) || (nxt_state == ST_OP_WAIT) ||
                       (nxt_state == ST_OP_END);
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_ff <= CTRL_RESET;
      end else begin
         if (ctrlWr) begin
            ctrl_ff.enable <= ctrlNew.enable;
            ctrl_ff.err    <= ctrlNew.err;
            ctrl_ff.erase  <= ctrlNew.erase;
            ctrl_ff.op     <= ctrlNew.op;
         end
         if (launch) begin
            ctrl_ff.start <= 1'b1;
         end
         if (state_ff == ST_OP_END) begin
            ctrl_ff.start <= 1'b0;
            ctrl_ff.err   <= opFail_ff;
         end
         if (badSeq) begin
            ctrl_ff.err <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Table pointer and mode
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         page_ff     <= PAGE_RESET;
         ea_ff       <= EA_RESET;
         byteMode_ff <= 1'b0;
      end else if (wrTake) begin
         if (avs_address == REG_PAGE && avs_byteenable[0]) begin
            page_ff <= avs_writedata[7:0];
         end
         if (avs_address == REG_EA) begin
            if (avs_byteenable[0]) begin
               ea_ff[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
               ea_ff[15:8] <= avs_writedata[15:8];
            end
         end
         if (avs_address == REG_TMODE && avs_byteenable[0]) begin
            byteMode_ff <= avs_writedata[TMODE_BYTE];
         end
      end
   end

   // ------------------------------------------------------------
   // Flash request
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fValid_ff <= 1'b0;
         fReq_ff   <= '0;
         idx_ff    <= '0;
         opFail_ff <= 1'b0;
         rdHigh_ff <= 1'b0;
      end else begin
         if (launch) begin
            idx_ff    <= '0;
            opFail_ff <= 1'b0;
         end
         if (state_ff == ST_IDLE && tblRd) begin
            fValid_ff    <= 1'b1;
            fReq_ff.cmd  <= FCMD_READ;
            fReq_ff.addr <= {tblAddr[23:1], 1'b0};
            fReq_ff.data <= 24'h000000;
            rdHigh_ff    <= (avs_address == REG_THIGH);
         end
         if (state_ff == ST_OP_ISSUE) begin
            fValid_ff    <= 1'b1;
            fReq_ff.data <= latchRdData;
            case (ctrl_ff.op)
               OP_ROW_PROG: begin
                  fReq_ff.cmd  <= FCMD_ROW_PROG;
                  fReq_ff.addr <= {tblAddr[23:ROW_BASE], idx_ff, 1'b0};
               end
               OP_WORD_PROG: begin
                  fReq_ff.cmd  <= FCMD_WORD_PROG;
                  fReq_ff.addr <= {tblAddr[23:1], 1'b0};
               end
               OP_PAGE_ERASE: begin
                  fReq_ff.cmd  <= FCMD_PAGE_ERASE;
                  fReq_ff.addr <= {tblAddr[23:BLOCK_BASE], 10'h000};
               end
               default: begin
                  fReq_ff.cmd  <= FCMD_BULK_ERASE;
                  fReq_ff.addr <= 24'h000000;
               end
            endcase
         end
         if (fValid_ff && flashAck) begin
            fValid_ff <= 1'b0;
         end
         if (state_ff == ST_OP_WAIT && flashAck) begin
            idx_ff <= ROW_IDX_W'(idx_ff + 1'b1);
            if (flashFail) begin
               opFail_ff <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   function automatic logic [31:0] fmtTable(input logic [WORD_W-1:0] w, input logic hi,
                                            input logic bm, input logic sel);
      logic [31:0] r;
      r = 32'h00000000;
      if (!hi) begin
         r[15:0] = bm ? {8'h00, (sel ? w[15:8] : w[7:0])} : w[15:0];
      end else if (!(bm && sel)) begin
         r[7:0] = w[23:16];
      end
      return r;
   endfunction : fmtTable

   logic [31:0] regMux;

   always_comb begin
      regMux = 32'h00000000;
      case (avs_address)
         REG_CTRL:   regMux[15:0] = ctrl_ff;
         REG_PAGE:   regMux[7:0]  = page_ff;
         REG_EA:     regMux[15:0] = ea_ff;
         REG_TMODE:  regMux[TMODE_BYTE] = byteMode_ff;
         REG_STATUS: begin
            regMux[STAT_BUSY]  = ctrl_ff.start;
            regMux[STAT_ARMED] = armed;
         end
         default:    regMux = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdData_ff <= 32'h00000000;
      end else if (rdTake && !tblRd) begin
         rdData_ff <= regMux;
      end else if (state_ff == ST_RD_WAIT && flashAck) begin
         rdData_ff <= fmtTable(flashRdData, rdHigh_ff, byteMode_ff, ea_ff[0]);
      end
   end

endmodule : fspc_top

/* File: hw/fspc_unlock_key.sv */
`timescale 1ns/1ps
module fspc_unlock_key
   import fspc_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // Accepted writes
   input  wire logic       keyWr,
   input  wire logic [7:0] keyByte,
   input  wire logic       otherWr,
   // Unlock state
   output logic            armed_ff
);

   logic firstSeen_ff;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         firstSeen_ff <= 1'b0;
         armed_ff     <= 1'b0;
      end else if (keyWr) begin
         firstSeen_ff <= (keyByte == KEY_FIRST);
         armed_ff     <= firstSeen_ff && (keyByte == KEY_SECOND);
      end else if (otherWr) begin
         // Any other write disarms
         firstSeen_ff <= 1'b0;
         armed_ff     <= 1'b0;
      end
   end

endmodule : fspc_unlock_key
